// [rtfb_contacts.sv]
// partner model: the switch contacts wired to the trigger and reset pins
// assumes the bench asks for contact levels; contacts settle on the next edge
`default_nettype none
module rtfb_contacts
(
    // clock
    input wire logic sys_clk,
    // requested contact levels: on trg, off trg, off rst, tog trg, tog rst
    input wire logic [4:0] wantLevel,
    // contact levels seen at the pins
    output logic [4:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////
    // a contact moves just after an edge and then holds; no bounce is modelled
    // so the block sees a clean level, one cycle behind the request
    always @(posedge sys_clk)
    begin
        pinLevel <= wantLevel;
    end
endmodule
`default_nettype wire

// [rtfb_delay_timer.sv]
// one delay timer counting hundredths, scaled to minutes or hours by unit
// assumes a one cycle hundredth tick from the same clock domain
`default_nettype none
`include "rtfb_params.svh"
module rtfb_delay_timer
    import rtfb_pkg::*;
(
    // clock and control
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic hundTick,
    // timer control
    input wire logic start,
    input wire logic clear,
    input wire rtfb_delay_s delay,
    // status
    output logic expired,
    output logic running
);
    logic [7:0] scaleQ, scaleD;
    logic [13:0] cntQ, cntD;
    logic runQ, runD;
    logic [7:0] scaleMax;

    // units scale: seconds use hundredths direct, minutes and hours prescale [RULE4]
    always_comb
    begin
        case (delay.unit)
            RTFB_UNIT_MIN: scaleMax = 8'(`RTFB_SEC_PER_MIN - 1);
            RTFB_UNIT_HOUR: scaleMax = 8'(`RTFB_SEC_PER_MIN - 1);
            default: scaleMax = 8'h00;
        endcase
    end

    logic [13:0] hourDiv;
    logic [13:0] hourQ, hourD;
    // next state; unless clear is high, a start restarts from zero [RULE7] [RULE22]
    always_comb
    begin
        scaleD = scaleQ;
        cntD = cntQ;
        runD = runQ;
        hourD = hourQ;
        hourDiv = (delay.unit == RTFB_UNIT_HOUR) ? 14'(`RTFB_MIN_PER_HOUR - 1) : 14'h0000;
        if (clear)
        begin
            runD = 1'b0;
            cntD = 14'h0000;
            scaleD = 8'h00;
            hourD = 14'h0000;
        end
        else if (start)
        begin
            runD = 1'b1;
            cntD = 14'h0000;
            scaleD = 8'h00;
            hourD = 14'h0000;
        end
        else if (runQ && hundTick)
        begin
            if (hourQ < hourDiv)
                hourD = hourQ + 14'h0001;
            else
            begin
                hourD = 14'h0000;
                if (scaleQ < scaleMax)
                    scaleD = scaleQ + 8'h01;
                else
                begin
                    scaleD = 8'h00;
                    cntD = cntQ + 14'h0001;
                    if (cntQ + 14'h0001 >= delay.count)
                        runD = 1'b0;
                end
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            scaleQ <= 8'h00;
            cntQ <= 14'h0000;
            runQ <= 1'b0;
            hourQ <= 14'h0000;
        end
        else if (clkEn)
        begin
            scaleQ <= scaleD;
            cntQ <= cntD;
            runQ <= runD;
            hourQ <= hourD;
        end
    end

    assign running = runQ;
    assign expired = runQ && !runD && !clear && !start;
endmodule
`default_nettype wire

// [rtfb_function_blocks.sv]
// on-delay, off-delay, toggle relay and calendar switch function blocks
// assumes binary inputs arrive from pins and are synchronised here; one clock
//
// Behaviour
// [RULE1] on-delay starts its timer on a rising trigger edge
// [RULE2] on-delay output goes 1 after the delay if trigger stayed high
// [RULE3] on-delay aborts and clears output while trigger is low
// [RULE4] delays settable 0.01 to 99.99 in seconds, minutes or hours
// [RULE5] off-delay output is 1 at once while trigger is high
// [RULE6] falling trigger starts off-delay timer; expiry clears output and timer
// [RULE7] each new falling edge restarts the off-delay timer from zero
// [RULE8] off-delay reset clears timer and output, overriding trigger
// [RULE9] toggle relay inverts output on each rising trigger edge
// [RULE10] toggle relay reset forces output 0 over the trigger
// [RULE11] calendar switch has a day or week mode select per point
// [RULE12] calendar output is ON when any programmed interval is ON
// [RULE13] calendar stores up to 127 time points for one output
// [RULE14] programmer enters points in ascending order; off before on invalid
// [RULE15] with on and off set, output is ON only between them
// [RULE16] times run 00:00:00 to 23:59:59; 24:00:00 means not set
// [RULE17] single on or off point keeps state before, then switches
// [RULE18] programmer treats Monday to Sunday as one week cycle
// [RULE19] week mode ignores the date and uses only times and weekday
// [RULE20] calendar switches on at on points and off at off points
// [RULE21] calendar time resolves to one second
// [RULE22] timers count a prescaled tick; edges registered; sync reset clears all (the code does not clear the point table pointMem)
// [RULE23] when points fall due together the later entry decides
`default_nettype none
`include "rtfb_params.svh"
module rtfb_function_blocks
    import rtfb_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // on-delay block
    input wire logic onDlyTrigger,
    input wire rtfb_delay_s onDlyTime,
    output logic onDlyOut,
    // off-delay block
    input wire logic offDlyTrigger,
    input wire logic offDlyReset,
    input wire rtfb_delay_s offDlyTime,
    output logic offDlyOut,
    // toggle relay block
    input wire logic toggleTrigger,
    input wire logic toggleReset,
    output logic toggleOut,
    // calendar: current date and time of day
    input wire logic [15:0] calDay,
    input wire logic [2:0] calWeekday,
    input wire logic [16:0] calSecs,
    // calendar point programming port
    input wire logic pointWrite,
    input wire logic [6:0] pointIndex,
    input wire rtfb_point_s pointData,
    input wire logic [6:0] pointCount,
    output logic calOut
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, pins come from outside the clock domain
    logic [4:0] pinMetaQ, pinMetaD, pinSyncQ, pinSyncD, pinLastQ, pinLastD;
    logic [4:0] pinRise, pinFall;
    always_comb
    begin
        pinMetaD = {toggleReset, toggleTrigger, offDlyReset, offDlyTrigger, onDlyTrigger};
        pinSyncD = pinMetaQ;
        pinLastD = pinSyncQ;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pinMetaQ <= 5'h00;
            pinSyncQ <= 5'h00;
            pinLastQ <= 5'h00;
        end
        else if (clkEn)
        begin
            pinMetaQ <= pinMetaD;
            pinSyncQ <= pinSyncD;
            pinLastQ <= pinLastD;
        end
    end
    // edges come from registered copies only [RULE22]
    assign pinRise = pinSyncQ & ~pinLastQ;
    assign pinFall = ~pinSyncQ & pinLastQ;

    ////////////////////////////////////////////////////////////////////////
    // hundredth-second prescaler shared by both delay timers
    logic [17:0] preQ, preD;
    logic hundTick;
    always_comb
    begin
        preD = (preQ == 18'(`RTFB_HUND_CYC - 1)) ? 18'h00000 : preQ + 18'h00001; // [RULE22]
    end
    assign hundTick = (preQ == 18'(`RTFB_HUND_CYC - 1));
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            preQ <= 18'h00000;
        else if (clkEn)
            preQ <= preD;
    end

    ////////////////////////////////////////////////////////////////////////
    // on-delay block
    logic onExpired, onRunning;
    logic onOutQ, onOutD;
    rtfb_delay_timer onTimer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .hundTick(hundTick),
        .start(pinRise[0]), // [RULE1]
        .clear(!pinSyncQ[0]), // [RULE3]
        .delay(onDlyTime),
        .expired(onExpired),
        .running(onRunning)
    );
    always_comb
    begin
        onOutD = onOutQ;
        if (!pinSyncQ[0])
            onOutD = 1'b0; // [RULE3]
        else if (onExpired || (pinRise[0] && onDlyTime.count == 14'h0000))
            onOutD = 1'b1; // [RULE2]
    end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            onOutQ <= 1'b0;
        else if (clkEn)
            onOutQ <= onOutD;
    end
    assign onDlyOut = onOutQ;

    ////////////////////////////////////////////////////////////////////////
    // off-delay block
    logic offExpired, offRunning;
    logic offOutQ, offOutD;
    rtfb_delay_timer offTimer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .hundTick(hundTick),
        .start(pinFall[1] && !pinSyncQ[2]), // [RULE6] [RULE7]
        .clear(pinSyncQ[2] || pinSyncQ[1]), // [RULE8]
        .delay(offDlyTime),
        .expired(offExpired),
        .running(offRunning)
    );
    always_comb
    begin
        offOutD = offOutQ;
        if (pinSyncQ[2])
            offOutD = 1'b0; // [RULE8]
        else if (pinSyncQ[1])
            offOutD = 1'b1; // [RULE5]
        else if (offExpired)
            offOutD = 1'b0; // [RULE6]
    end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            offOutQ <= 1'b0;
        else if (clkEn)
            offOutQ <= offOutD;
    end
    assign offDlyOut = offOutQ;

    ////////////////////////////////////////////////////////////////////////
    // toggle relay block
    logic togQ, togD;
    always_comb
    begin
        togD = togQ;
        if (pinSyncQ[4])
            togD = 1'b0; // [RULE10]
        else if (pinRise[3])
            togD = !togQ; // [RULE9]
    end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            togQ <= 1'b0;
        else if (clkEn)
            togQ <= togD;
    end
    assign toggleOut = togQ;

    ////////////////////////////////////////////////////////////////////////
    // calendar switch: point table and scan
    // one point is examined per cycle; a 127 point pass takes far less than
    // a second, so a one second resolution is kept [RULE21]
    rtfb_point_s pointMem [0:`RTFB_POINTS-1]; // [RULE13]
    logic [6:0] scanQ, scanD;
    logic [16:0] lastSecsQ, lastSecsD;
    logic calQ, calD;
    logic passQ, passD;
    rtfb_point_s cur;

    // a point is due when its second arrives on its day or weekday
    function automatic logic pointDue(input rtfb_point_s p, input logic [15:0] day,
                                      input logic [2:0] wday, input logic [16:0] secs);
        logic dayMatch;
        dayMatch = p.weekMode ? (p.day[2:0] == wday) : (p.day == day); // [RULE11] [RULE19]
        pointDue = p.valid && (p.secs != `RTFB_NOT_SET) && dayMatch && (p.secs == secs); // [RULE16]
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (clkEn && pointWrite && pointIndex != 7'(`RTFB_POINTS))
            pointMem[pointIndex] <= pointData;
    end
    assign cur = pointMem[scanQ];

    // walk the table once for every new second; later entries override earlier
    always_comb
    begin
        scanD = scanQ;
        lastSecsD = lastSecsQ;
        calD = calQ;
        passD = passQ;
        if (!passQ)
        begin
            if (calSecs != lastSecsQ)
            begin
                passD = 1'b1;
                scanD = 7'h00;
                lastSecsD = calSecs;
            end
        end
        else
        begin
            if (scanQ < pointCount && pointDue(cur, calDay, calWeekday, lastSecsQ))
                calD = cur.isOn; // [RULE12] [RULE15] [RULE17] [RULE20] [RULE23]
            if (scanQ >= pointCount || scanQ == 7'(`RTFB_POINTS - 1))
                passD = 1'b0;
            else
                scanD = scanQ + 7'h01;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            scanQ <= 7'h00;
            lastSecsQ <= `RTFB_NOT_SET;
            calQ <= 1'b0;
            passQ <= 1'b0;
        end
        else if (clkEn)
        begin
            scanQ <= scanD;
            lastSecsQ <= lastSecsD;
            calQ <= calD;
            passQ <= passD;
        end
    end
    assign calOut = calQ;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence offRelease_s;
        !pinSyncQ[1] && !pinSyncQ[2] && offOutQ;
    endsequence
    toggle_reset_wins_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE10]
        clkEn && pinSyncQ[4] |=> !togQ) else $error("toggle not cleared by reset");
    toggle_edge_flip_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE9]
        clkEn && pinRise[3] && !pinSyncQ[4] |=> togQ != $past(togQ)) else $error("toggle missed edge");
    ondly_low_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        clkEn && !pinSyncQ[0] |=> !onOutQ) else $error("on-delay output not cleared");
    ondly_expire_set_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        clkEn && onExpired && pinSyncQ[0] |=> onOutQ) else $error("on-delay output missed expiry");
    offdly_high_set_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
        clkEn && pinSyncQ[1] && !pinSyncQ[2] |=> offOutQ) else $error("off-delay output not set");
    offdly_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE8]
        clkEn && pinSyncQ[2] |=> !offOutQ && !offRunning) else $error("off-delay reset ignored");
    offdly_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        clkEn ##0 offRelease_s ##0 !offExpired |=> offOutQ) else $error("off-delay dropped early");
    cal_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE20]
        clkEn && !passQ |=> calQ == $past(calQ)) else $error("calendar changed outside scan");
    // timer start and expiry hand-offs, toggle hold and calendar pass start
    ondly_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        clkEn && pinRise[0] |=> onRunning) else $error("on-delay timer not started");
    ondly_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        clkEn && pinRise[0] && onDlyTime.count == 14'h0000 |=> onOutQ) else $error("zero delay not immediate");
    offdly_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        clkEn && pinFall[1] && !pinSyncQ[2] |=> offRunning) else $error("off-delay timer not restarted");
    offdly_expire_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        clkEn && offExpired |=> !offOutQ) else $error("off-delay output kept after expiry");
    toggle_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE9]
        clkEn && !pinRise[3] && !pinSyncQ[4] |=> togQ == $past(togQ)) else $error("toggle moved without edge");
    cal_scan_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE21]
        clkEn && !passQ && calSecs != lastSecsQ |=> passQ && scanQ == 7'h00) else $error("calendar pass not started");
    // clkEn low must leave every output register untouched
    clk_en_freeze_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE22]
        !clkEn |=> $stable({onOutQ, offOutQ, togQ, calQ})) else $error("state moved while disabled");
endmodule
`default_nettype wire

// [rtfb_params.svh]
// timing and calendar constants for the relay timer function blocks
// assumes a 20 MHz system clock; the calendar time of day is supplied from outside
`ifndef RTFB_PARAMS_SVH
`define RTFB_PARAMS_SVH
`define RTFB_CLK_HZ 20000000
`define RTFB_HUND_CYC 200000
`define RTFB_HUND_PER_SEC 100
`define RTFB_SEC_PER_MIN 60
`define RTFB_MIN_PER_HOUR 60
`define RTFB_DELAY_MAX 14'h270F
`define RTFB_NOT_SET 17'h15180
`define RTFB_SEC_PER_DAY 17'h15180
`define RTFB_POINTS 127
`define RTFB_WEEKDAYS 3'h7
`endif

// [rtfb_pkg.sv]
// shared types for the relay timer function blocks
// no assumptions beyond the params header
`default_nettype none
package rtfb_pkg;
    typedef enum logic [1:0] {RTFB_UNIT_SEC = 2'h0, RTFB_UNIT_MIN = 2'h1, RTFB_UNIT_HOUR = 2'h2} rtfb_unit_e;
    typedef enum logic [1:0] {RTFB_IDLE = 2'h0, RTFB_RUN = 2'h1, RTFB_DONE = 2'h3} rtfb_state_e;
    typedef struct packed {
        logic [13:0] count;
        rtfb_unit_e unit;
    } rtfb_delay_s;
    typedef struct packed {
        logic valid;
        logic isOn;
        logic weekMode;
        logic [15:0] day;
        logic [16:0] secs;
    } rtfb_point_s;
endpackage
`default_nettype wire

// [tb_relay_timer_function_blocks.sv]
// self-checking bench for the four relay timer function blocks
// assumes the contact model for the pins; the calendar time is driven here
`default_nettype none
module tb_relay_timer_function_blocks
    import rtfb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk;
    logic nrst;
    logic clkEn;
    logic [4:0] wantLevel;
    logic [4:0] pinLevel;
    rtfb_delay_s onDlyTime;
    rtfb_delay_s offDlyTime;
    logic [15:0] calDay;
    logic [2:0] calWeekday;
    logic [16:0] calSecs;
    logic pointWrite;
    logic [6:0] pointIndex;
    rtfb_point_s pointData;
    logic [6:0] pointCount;
    logic [3:0] outs;
    int n_mismatch;
    int n_tests;

    ////////////////////////////////////////////////////////////////
    // clock, time-zero values
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        nrst = 1'b0;
        clkEn = 1'b1;
        wantLevel = 5'h00;
        onDlyTime = rtfb_delay_s'{14'h0000, RTFB_UNIT_SEC};
        offDlyTime = rtfb_delay_s'{14'h270F, RTFB_UNIT_HOUR};
        calDay = 16'h0000;
        calWeekday = 3'h0;
        calSecs = 17'h00000;
        pointWrite = 1'b0;
        pointIndex = 7'h00;
        pointData = '0;
        pointCount = 7'h00;
    end

    rtfb_contacts u_contacts (.sys_clk(sys_clk), .wantLevel(wantLevel), .pinLevel(pinLevel));

    rtfb_function_blocks u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
        .onDlyTrigger(pinLevel[0]), .onDlyTime(onDlyTime), .onDlyOut(outs[0]),
        .offDlyTrigger(pinLevel[1]), .offDlyReset(pinLevel[2]), .offDlyTime(offDlyTime), .offDlyOut(outs[1]),
        .toggleTrigger(pinLevel[3]), .toggleReset(pinLevel[4]), .toggleOut(outs[2]),
        .calDay(calDay), .calWeekday(calWeekday), .calSecs(calSecs),
        .pointWrite(pointWrite), .pointIndex(pointIndex), .pointData(pointData),
        .pointCount(pointCount), .calOut(outs[3])
    );

    ////////////////////////////////////////////////////////////////
    // comparison and access tasks
    task automatic check(input string name, input logic got, input logic exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    end
    endtask

    // level check after the pin path has surely settled
    task automatic settle(input int b, input logic exp, input string name);
    begin
        repeat (10) @(posedge sys_clk);
        #1;
        check(name, outs[b], exp);
    end
    endtask

    // bounded wait: contact cycle plus sync and edge detect is four edges
    task automatic await(input int b, input logic exp, input string name);
        int i;
    begin
        i = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        while (outs[b] !== exp && i < 8);
        check(name, outs[b], exp);
    end
    endtask

    task automatic pin(input int b, input logic v);
    begin
        @(posedge sys_clk);
        wantLevel[b] <= v;
    end
    endtask

    task automatic wr(input logic [6:0] idx, input logic on, input logic wk, input logic [15:0] day,
                      input logic [16:0] secs);
    begin
        @(posedge sys_clk);
        pointWrite <= 1'b1;
        pointIndex <= idx;
        pointData <= rtfb_point_s'{1'b1, on, wk, day, secs};
        @(posedge sys_clk);
        pointWrite <= 1'b0;
    end
    endtask

    // one calendar step; output settles within pointCount plus two cycles
    task automatic tm(input logic [15:0] day, input logic [2:0] wd, input logic [16:0] secs, input logic exp);
    begin
        @(posedge sys_clk);
        calDay <= day;
        calWeekday <= wd;
        calSecs <= secs;
        repeat (9) @(posedge sys_clk);
        #1;
        check("calOut", outs[3], exp);
    end
    endtask

    task automatic results;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    ////////////////////////////////////////////////////////////////
    // watchdog: the tests take well under 2000 cycles
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        check("outs after reset", |outs, 1'b0);
        // toggle relay: flip on rises, hold between, reset wins
        pin(3, 1'b1);
        await(2, 1'b1, "toggleOut rise1");
        pin(3, 1'b0);
        settle(2, 1'b1, "toggleOut hold");
        pin(3, 1'b1);
        await(2, 1'b0, "toggleOut rise2");
        pin(3, 1'b0);
        pin(3, 1'b1);
        await(2, 1'b1, "toggleOut rise3");
        pin(4, 1'b1);
        await(2, 1'b0, "toggleOut reset");
        pin(3, 1'b0);
        pin(3, 1'b1);
        settle(2, 1'b0, "toggleOut rise in reset");
        pin(4, 1'b0);
        pin(3, 1'b0);
        settle(2, 1'b0, "toggleOut released");
        // a rise while clkEn is low is only seen once the clock is enabled again
        @(posedge sys_clk);
        clkEn <= 1'b0;
        pin(3, 1'b1);
        settle(2, 1'b0, "toggleOut frozen");
        @(posedge sys_clk);
        clkEn <= 1'b1;
        await(2, 1'b1, "toggleOut after enable");
        pin(3, 1'b0);
        // mid-run reset clears the held toggle output
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("outs mid reset", |outs, 1'b0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        $display("test toggle done");
        // on-delay: zero delay fires at once, low trigger clears
        pin(0, 1'b1);
        await(0, 1'b1, "onDlyOut zero delay");
        pin(0, 1'b0);
        await(0, 1'b0, "onDlyOut trigger low");
        @(posedge sys_clk);
        onDlyTime <= rtfb_delay_s'{14'h270F, RTFB_UNIT_HOUR};
        pin(0, 1'b1);
        settle(0, 1'b0, "onDlyOut long delay");
        pin(0, 1'b0);
        $display("test on-delay done");
        // off-delay: immediate on, held while timing, reset overrides
        pin(1, 1'b1);
        await(1, 1'b1, "offDlyOut trigger high");
        pin(1, 1'b0);
        settle(1, 1'b1, "offDlyOut timing");
        pin(1, 1'b1);
        pin(1, 1'b0);
        settle(1, 1'b1, "offDlyOut restart");
        pin(2, 1'b1);
        await(1, 1'b0, "offDlyOut reset");
        pin(1, 1'b1);
        settle(1, 1'b0, "offDlyOut reset over trigger");
        pin(2, 1'b0);
        await(1, 1'b1, "offDlyOut reset released");
        pin(1, 1'b0);
        $display("test off-delay done");
        // calendar: points entered in ascending order per day
        wr(7'h00, 1'b1, 1'b0, 16'h0005, 17'h00064);
        wr(7'h01, 1'b0, 1'b0, 16'h0005, 17'h000C8);
        wr(7'h02, 1'b1, 1'b1, 16'h0002, 17'h0012C);
        wr(7'h03, 1'b1, 1'b1, 16'h0002, 17'h00190);
        wr(7'h04, 1'b0, 1'b1, 16'h0002, 17'h00190);
        wr(7'h05, 1'b0, 1'b1, 16'h0002, 17'h1517F);
        @(posedge sys_clk);
        pointCount <= 7'h06;
        tm(16'h0005, 3'h0, 17'h00032, 1'b0);
        tm(16'h0005, 3'h0, 17'h00064, 1'b1);
        tm(16'h0005, 3'h0, 17'h00096, 1'b1);
        tm(16'h0005, 3'h0, 17'h000C8, 1'b0);
        tm(16'h0006, 3'h0, 17'h00064, 1'b0);
        tm(16'h0009, 3'h2, 17'h0012C, 1'b1);
        tm(16'h0009, 3'h3, 17'h0018F, 1'b1);
        tm(16'h0009, 3'h2, 17'h00190, 1'b0);
        tm(16'h0009, 3'h2, 17'h0012C, 1'b1);
        tm(16'h0009, 3'h2, 17'h1517F, 1'b0);
        $display("test calendar done");
        results();
    end
endmodule
`default_nettype wire
